// ==== src/jls_pkg.sv ====
// Constants shared by the lane synchronisation status block.
package jls_pkg;

    // ========================================================================
    // Register indices and byte addresses
    // ========================================================================
    // Register indices; the APB byte address is four times the index.
    localparam logic [13:0] IDX_LINK_PAGE = 14'h0300;
    localparam logic [13:0] IDX_STRAY_SYM = 14'h046f;
    localparam logic [13:0] IDX_SYM_LOCK = 14'h0470;
    localparam logic [13:0] IDX_FRM_LOCK = 14'h0471;
    localparam logic [13:0] IDX_ERR_LIMIT = 14'h0474;
    localparam logic [13:0] IDX_IRQ_STATUS = 14'h0475;
    localparam logic [13:0] IDX_IRQ_CLEAR = 14'h0476;
    localparam logic [13:0] IDX_IRQ_ENABLE = 14'h0477;

    localparam int unsigned ADDR_W = 16;
    localparam logic [15:0] ADDR_LINK_PAGE = {IDX_LINK_PAGE, 2'b00};
    localparam logic [15:0] ADDR_STRAY_SYM = {IDX_STRAY_SYM, 2'b00};
    localparam logic [15:0] ADDR_SYM_LOCK = {IDX_SYM_LOCK, 2'b00};
    localparam logic [15:0] ADDR_FRM_LOCK = {IDX_FRM_LOCK, 2'b00};
    localparam logic [15:0] ADDR_ERR_LIMIT = {IDX_ERR_LIMIT, 2'b00};
    localparam logic [15:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [15:0] ADDR_IRQ_CLEAR = {IDX_IRQ_CLEAR, 2'b00};
    localparam logic [15:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};

    // ========================================================================
    // Reset values and field positions
    // ========================================================================
    localparam logic [7:0] RST_LANE_STATUS = 8'h00;
    localparam logic [7:0] RST_ERR_LIMIT = 8'hff;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // Interrupt status bits, the same layout in status, clear and enable.
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_SYM_LOST = 0;
    localparam int unsigned IRQ_FRM_LOST = 1;
    localparam int unsigned IRQ_ERR_RISE = 2;
    localparam logic [2:0] RST_IRQ = 3'h0;

endpackage

// ==== src/jls_sync_status.sv ====
// Per-lane symbol, framing and stray control symbol status with APB access.
`timescale 1ns/1ns
`default_nettype none

module jls_sync_status
    import jls_pkg::*;
#(
    parameter int unsigned LANES = 8,
    parameter int unsigned ERR_W = 8,
    parameter int unsigned PAGE_W = 1,
    parameter int unsigned NUM_LINKS = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_LINKS*LANES-1:0] symLockIn,
    input wire logic [NUM_LINKS*LANES-1:0] frameLockIn,
    input wire logic [NUM_LINKS*LANES*ERR_W-1:0] errCountIn,
    output logic irq
);

    localparam int unsigned NB = NUM_LINKS * LANES;

    // ========================================================================
    // Lane status capture
    // ========================================================================
    logic [NB-1:0] symLock_q;
    logic [NB-1:0] symLock_d;
    logic [NB-1:0] frmLock_q;
    logic [NB-1:0] frmLock_d;
    logic [NB-1:0] errFlag_q;
    logic [NB-1:0] errFlag_d;
    logic [ERR_W-1:0] errLimit_q;
    logic [ERR_W-1:0] errLimit_d;
    logic [PAGE_W-1:0] pageSel_q;
    logic [PAGE_W-1:0] pageSel_d;

    // Each lane compares its own error count with the shared limit.
    genvar k;
    generate
        for (k = 0; k < NB; k++) begin : gLane
            assign errFlag_d[k] =
                (errCountIn[k*ERR_W +: ERR_W] >= errLimit_q);

            // A count that reaches the limit must raise the lane's flag; the
            // compare is at-or-above, so equality alone is enough.
            errFlagSet_a: assert property (
                @(posedge clk) disable iff (srst)
                !$past(srst) &&
                ($past(errCountIn[k*ERR_W +: ERR_W]) >= $past(errLimit_q))
                |-> errFlag_q[k])
                else $error("Lane error flag stayed low at the limit.");

            // A count below the limit must leave the flag low.
            errFlagClr_a: assert property (
                @(posedge clk) disable iff (srst)
                !$past(srst) &&
                ($past(errCountIn[k*ERR_W +: ERR_W]) < $past(errLimit_q))
                |-> !errFlag_q[k])
                else $error("Lane error flag was set below the limit.");
        end
    endgenerate

    // Lock inputs come from receiver logic on this clock, so no synchroniser.
    always_comb begin
        symLock_d = symLockIn;
        frmLock_d = frameLockIn;
    end

    // Status flops clear on reset and are only ever loaded from the lanes.
    always_ff @(posedge clk) begin
        if (srst) begin
            symLock_q <= '0;
            frmLock_q <= '0;
            errFlag_q <= '0;
        end else begin
            symLock_q <= symLock_d;
            frmLock_q <= frmLock_d;
            errFlag_q <= errFlag_d;
        end
    end

    // Paged view of the selected link; the page is an index, not a mask.
    logic [LANES-1:0] symView;
    logic [LANES-1:0] frmView;
    logic [LANES-1:0] errView;
    always_comb begin
        symView = symLock_q[pageSel_q*LANES +: LANES];
        frmView = frmLock_q[pageSel_q*LANES +: LANES];
        errView = errFlag_q[pageSel_q*LANES +: LANES];
    end

    // ========================================================================
    // APB slave
    // ========================================================================
    logic setupPh;
    logic wrEn;
    logic mapped;
    logic [31:0] rdMux;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [IRQ_W-1:0] irqSta_q;
    logic [IRQ_W-1:0] irqSta_d;
    logic [IRQ_W-1:0] irqEn_q;
    logic [IRQ_W-1:0] irqEn_d;
    logic irq_q;
    logic irq_d;

    // A write lands only on the access edge at which pready is seen high.
    always_comb begin
        setupPh = psel && !penable;
        wrEn = psel && penable && pready_q && pwrite;
    end

    // Read decode; unmapped addresses answer with an error and zero data.
    always_comb begin
        rdMux = RST_RDATA;
        mapped = 1'b1;
        case (paddr)
            ADDR_LINK_PAGE: rdMux[PAGE_W-1:0] = pageSel_q;
            ADDR_STRAY_SYM: rdMux[LANES-1:0] = errView;
            ADDR_SYM_LOCK: rdMux[LANES-1:0] = symView;
            ADDR_FRM_LOCK: rdMux[LANES-1:0] = frmView;
            ADDR_ERR_LIMIT: rdMux[ERR_W-1:0] = errLimit_q;
            ADDR_IRQ_STATUS: rdMux[IRQ_W-1:0] = irqSta_q;
            ADDR_IRQ_CLEAR: rdMux = RST_RDATA;
            ADDR_IRQ_ENABLE: rdMux[IRQ_W-1:0] = irqEn_q;
            default: mapped = 1'b0;
        endcase
    end

    // The answer is prepared in the setup cycle so pready can come from a
    // flop: every transfer takes exactly one access cycle, no wait states.
    always_comb begin
        prdata_d = prdata_q;
        pready_d = setupPh && !pready_q;
        pslverr_d = 1'b0;
        if (setupPh) begin
            prdata_d = pwrite ? RST_RDATA : rdMux;
            pslverr_d = !mapped;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_q <= RST_RDATA;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ========================================================================
    // Writable registers
    // ========================================================================
    // Status addresses are absent here, so writes to them fall away.
    always_comb begin
        pageSel_d = pageSel_q;
        errLimit_d = errLimit_q;
        irqEn_d = irqEn_q;
        if (wrEn && !pslverr_q) begin
            case (paddr)
                ADDR_LINK_PAGE: pageSel_d = pwdata[PAGE_W-1:0];
                ADDR_ERR_LIMIT: errLimit_d = pwdata[ERR_W-1:0];
                ADDR_IRQ_ENABLE: irqEn_d = pwdata[IRQ_W-1:0];
                default: pageSel_d = pageSel_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pageSel_q <= '0;
            errLimit_q <= RST_ERR_LIMIT[ERR_W-1:0];
            irqEn_q <= RST_IRQ;
        end else begin
            pageSel_q <= pageSel_d;
            errLimit_q <= errLimit_d;
            irqEn_q <= irqEn_d;
        end
    end

    // ========================================================================
    // Interrupts
    // ========================================================================
    // Events are taken over all links, not just the paged one, so a fault on
    // a link software is not looking at still raises the interrupt.
    logic [IRQ_W-1:0] irqEvt;
    logic [IRQ_W-1:0] irqClr;
    always_comb begin
        irqEvt = '0;
        irqEvt[IRQ_SYM_LOST] = |(symLock_q & ~symLock_d);
        irqEvt[IRQ_FRM_LOST] = |(frmLock_q & ~frmLock_d);
        irqEvt[IRQ_ERR_RISE] = |(errFlag_d & ~errFlag_q);
        irqClr = '0;
        if (wrEn && (paddr == ADDR_IRQ_CLEAR)) begin
            irqClr = pwdata[IRQ_W-1:0];
        end
        // A new event in the clearing cycle wins over the clear.
        irqSta_d = (irqSta_q & ~irqClr) | irqEvt;
        irq_d = |(irqSta_d & irqEn_d);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irqSta_q <= RST_IRQ;
            irq_q <= 1'b0;
        end else begin
            irqSta_q <= irqSta_d;
            irq_q <= irq_d;
        end
    end

    // Every output comes straight from a flop.
    always_comb begin
        prdata = prdata_q;
        pready = pready_q;
        pslverr = pslverr_q;
        irq = irq_q;
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    // The lane copy, error flag and sticky checks skip the first edge after reset, where the flops still hold
    // their reset values and a look one clock back would see stale lanes.

    // Lock status is the lane state of one clock ago, never older, so a
    // lane that drops out shows on the very next read.
    symLockCopy_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> (symLock_q == $past(symLockIn)))
        else $error("Symbol lock status lags its lanes.");

    // Framing lock follows its lanes with the same single clock of delay.
    frmLockCopy_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> (frmLock_q == $past(frameLockIn)))
        else $error("Framing lock status lags its lanes.");

    // Reset leaves every status bit and the interrupt line at zero.
    rstClear_a: assert property (@(posedge clk)
        $past(srst) |->
        (symLock_q == '0) && (frmLock_q == '0) && (errFlag_q == '0) &&
        (irqSta_q == RST_IRQ) && !irq_q)
        else $error("Status was not cleared by reset.");

    // Page zero shows lanes 0 to 7 of the first link, untouched.
    pageZero_a: assert property (@(posedge clk) disable iff (srst)
        (pageSel_q == '0) |->
        (symView == symLock_q[LANES-1:0]) &&
        (frmView == frmLock_q[LANES-1:0]) &&
        (errView == errFlag_q[LANES-1:0]))
        else $error("Page zero does not show the first link.");

    // A read answers in the access cycle with the paged byte, zero above.
    symReadBack_a: assert property (@(posedge clk) disable iff (srst)
        setupPh && !pwrite && (paddr == ADDR_SYM_LOCK) |=>
        (prdata == {{(32-LANES){1'b0}},
        $past(symLock_q[pageSel_q*LANES +: LANES])}))
        else $error("Symbol lock read returned the wrong byte.");

    // Framing lock reads follow the same page as symbol lock reads.
    frmReadBack_a: assert property (@(posedge clk) disable iff (srst)
        setupPh && !pwrite && (paddr == ADDR_FRM_LOCK) |=>
        (prdata == {{(32-LANES){1'b0}},
        $past(frmLock_q[pageSel_q*LANES +: LANES])}))
        else $error("Framing lock read returned the wrong byte.");

    // Stray control symbol flags read back from the paged link as well.
    errReadBack_a: assert property (@(posedge clk) disable iff (srst)
        setupPh && !pwrite && (paddr == ADDR_STRAY_SYM) |=>
        (prdata == {{(32-LANES){1'b0}},
        $past(errFlag_q[pageSel_q*LANES +: LANES])}))
        else $error("Stray symbol read returned the wrong byte.");

    // Writes aimed at status words must leave every writable field alone.
    logic roHit;
    always_comb begin
        roHit = (paddr == ADDR_SYM_LOCK) || (paddr == ADDR_FRM_LOCK) ||
            (paddr == ADDR_STRAY_SYM) || (paddr == ADDR_IRQ_STATUS);
    end
    roNoWrite_a: assert property (@(posedge clk) disable iff (srst)
        wrEn && roHit |=>
        $stable(pageSel_q) && $stable(errLimit_q) && $stable(irqEn_q))
        else $error("A write to a status word changed a register.");

    // The line is a pure level of enabled sticky bits; a pulse would be
    // lost by software that polls rather than takes the interrupt.
    irqLevel_a: assert property (@(posedge clk) disable iff (srst)
        irq_q == |(irqSta_q & irqEn_q))
        else $error("Interrupt line disagrees with enabled status.");

    // Losing symbol lock on any lane of any link latches its event.
    symLostEvt_a: assert property (@(posedge clk) disable iff (srst)
        |(symLock_q & ~symLockIn) |=> irqSta_q[IRQ_SYM_LOST])
        else $error("Symbol lock loss did not set its status bit.");

    // Losing framing lock on any lane of any link latches its event.
    frmLostEvt_a: assert property (@(posedge clk) disable iff (srst)
        |(frmLock_q & ~frameLockIn) |=> irqSta_q[IRQ_FRM_LOST])
        else $error("Framing lock loss did not set its status bit.");

    // A lane flag that rises latches the error event.
    errRiseEvt_a: assert property (@(posedge clk) disable iff (srst)
        |(errFlag_d & ~errFlag_q) |=> irqSta_q[IRQ_ERR_RISE])
        else $error("Error flag rise did not set its status bit.");

    // Clearing a bit works when no new event lands in the same cycle.
    symLostClr_a: assert property (@(posedge clk) disable iff (srst)
        wrEn && (paddr == ADDR_IRQ_CLEAR) && pwdata[IRQ_SYM_LOST] &&
        !(|(symLock_q & ~symLockIn)) |=> !irqSta_q[IRQ_SYM_LOST])
        else $error("Clear did not drop the symbol lock loss bit.");

    // Status bits stay set until software clears them: a missed event is
    // worse than a late one, so nothing else may drop them.
    logic [IRQ_W-1:0] irqKeep;
    always_comb begin
        irqKeep = irqSta_q & ~irqClr;
    end
    irqSticky_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> ((irqSta_q & $past(irqKeep)) == $past(irqKeep)))
        else $error("An interrupt status bit dropped without a clear.");

endmodule

`default_nettype wire

// ==== bench/jls_lane_partner.sv ====
// Behavioural model of the far-end transmitter's lane lock and error state.
`timescale 1ns/1ns
`default_nettype none
module jls_lane_partner #(
    parameter int unsigned N = 16
) (
    input wire logic clk,
    input wire logic [N-1:0] wantSym,
    input wire logic [N-1:0] wantFrm,
    input wire logic [N*8-1:0] wantErr,
    output logic [N-1:0] symLock,
    output logic [N-1:0] frmLock,
    output logic [N*8-1:0] errCount
);
    // ========================================================================
    // Lane state
    // ========================================================================
    // Framing lock is only held where symbol lock is held, as on a real link.
    always_ff @(posedge clk) begin
        symLock <= wantSym;
        frmLock <= wantFrm & wantSym;
        errCount <= wantErr;
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the lane synchronisation status block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import jls_pkg::*;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [15:0] paddr, wSym, wFrm, symLockIn, frameLockIn;
    logic [31:0] pwdata, prdata, rd;
    logic [127:0] wErr, errCountIn;
    int miscompares = 0;
    int compares = 0;

    jls_sync_status DUT (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .symLockIn(symLockIn), .frameLockIn(frameLockIn),
        .errCountIn(errCountIn), .irq(irq));
    jls_lane_partner partner (.clk(clk), .wantSym(wSym), .wantFrm(wFrm),
        .wantErr(wErr), .symLock(symLockIn), .frmLock(frameLockIn),
        .errCount(errCountIn));

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; an edge passes first so a release never meets a
    // raise in the same time step.
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 64) miscompares++;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // The line is registered after a write lands, so look two edges later.
    task automatic irqchk(input logic exp);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    task automatic lanes(input logic [15:0] s, input logic [15:0] f);
        wSym <= s;
        wFrm <= f;
        repeat (4) @(posedge clk);
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_lock();
        lanes(16'h5aa5, 16'h1821);
        apb(1'b1, ADDR_LINK_PAGE, 32'h0000_0000);
        rchk(ADDR_SYM_LOCK, 32'h0000_00a5);
        rchk(ADDR_FRM_LOCK, 32'h0000_0021);
        apb(1'b1, ADDR_LINK_PAGE, 32'h0000_0001);
        rchk(ADDR_SYM_LOCK, 32'h0000_005a);
        rchk(ADDR_FRM_LOCK, 32'h0000_0018);
        lanes(16'h5a80, 16'h1821);
        apb(1'b1, ADDR_LINK_PAGE, 32'h0000_0000);
        rchk(ADDR_SYM_LOCK, 32'h0000_0080);
        rchk(ADDR_FRM_LOCK, 32'h0000_0000);
    endtask

    // Counts straddle the limit by one on each side of equality.
    task automatic t_err();
        wErr <= {64'h0f0f_0f0f_0f0f_0f0f, 64'h200f_10ff_0011_100f};
        apb(1'b1, ADDR_ERR_LIMIT, 32'h0000_0010);
        rchk(ADDR_STRAY_SYM, 32'h0000_00b6);
        apb(1'b1, ADDR_LINK_PAGE, 32'h0000_0001);
        rchk(ADDR_STRAY_SYM, 32'h0000_0000);
        apb(1'b1, ADDR_ERR_LIMIT, 32'h0000_0000);
        rchk(ADDR_STRAY_SYM, 32'h0000_00ff);
    endtask

    // Writes to status places and to an unmapped word change nothing.
    task automatic t_ro();
        apb(1'b1, ADDR_SYM_LOCK, 32'h0000_00ff);
        apb(1'b1, ADDR_FRM_LOCK, 32'h0000_00ff);
        apb(1'b1, ADDR_STRAY_SYM, 32'h0000_0000);
        apb(1'b1, 16'h0010, 32'hffff_ffff);
        check({31'h0, err}, 32'h0000_0001);
        rchk(ADDR_SYM_LOCK, 32'h0000_005a);
        rchk(ADDR_FRM_LOCK, 32'h0000_0018);
        rchk(ADDR_STRAY_SYM, 32'h0000_00ff);
        check({31'h0, err}, 32'h0000_0000);
        rchk(ADDR_LINK_PAGE, 32'h0000_0001);
    endtask

    // Lock loss raises the line; mask, unmask and clear follow, then a
    // rise of the error flags raises it through its own enable bit.
    task automatic t_irq();
        apb(1'b1, ADDR_LINK_PAGE, 32'h0000_0000);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h0000_0007);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001 << IRQ_SYM_LOST);
        irqchk(1'b0);
        lanes(16'h5a00, 16'h0000);
        irqchk(1'b1);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0000_0000);
        check(rd, (32'h1 << IRQ_SYM_LOST) | (32'h1 << IRQ_FRM_LOST));
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0000);
        irqchk(1'b0);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001 << IRQ_SYM_LOST);
        irqchk(1'b1);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h0000_0007);
        irqchk(1'b0);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001 << IRQ_ERR_RISE);
        apb(1'b1, ADDR_ERR_LIMIT, 32'h0000_00ff);
        irqchk(1'b0);
        apb(1'b1, ADDR_ERR_LIMIT, 32'h0000_0010);
        irqchk(1'b1);
    endtask

    task automatic complete_run();
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ========================================================================
    // Clock, watchdog and main sequence
    // ========================================================================
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The whole run needs under two hundred cycles; this bound is generous.
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end

    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {wSym, wFrm, wErr} = '0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rchk(ADDR_SYM_LOCK, 32'h0000_0000);
        rchk(ADDR_STRAY_SYM, 32'h0000_0000);
        t_lock();
        t_err();
        t_ro();
        t_irq();
        complete_run();
    end
endmodule
`default_nettype wire
